// ---- core/pix_sensor.sv ----
/*
 * sensor end: divided pixel timing, frame-start pulse, line-valid, data
 * assumes the host drives enable and reset on the same clock
 */
`timescale 1ns/100ps
module pix_sensor
    import pix_port_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               reset_n_i,
    // settings and pixel input
    input  wire logic [DIV_W-1:0]   clk_div_i,
    input  wire logic [BLANK_W-1:0] blank_len_i,
    input  wire logic [DATA_W-1:0]  pixel_i,
    // link
    pix_port_if.sensor              link
);

    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_BLANK, ST_LINES} st_t;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic en_s1_r, en_s2_r, rst_s1_r, rst_s2_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_s1_r  <= 1'b0;
            en_s2_r  <= 1'b0;
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            en_s1_r  <= link.sensor_enable_in;
            en_s2_r  <= en_s1_r;
            rst_s1_r <= link.hw_reset_n;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ----------------------------------------
    // timing state
    // ----------------------------------------
    st_t               st_r, st_nxt;
    logic [DIV_W-1:0]  div_r, div_nxt;
    logic [COL_W-1:0]  col_r, col_nxt;
    logic [ROW_W-1:0]  row_r, row_nxt;
    logic [BLANK_W-1:0] blk_r, blk_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic              lv_r, lv_nxt;
    logic              fs_r, fs_nxt;
    logic              tick;
    logic              run;

    assign run  = en_s2_r && rst_s2_r;
    assign tick = (div_r == clk_div_i);

    always_comb begin
        st_nxt   = st_r;
        div_nxt  = tick ? DIV_RST : div_r + 1'b1;
        col_nxt  = col_r;
        row_nxt  = row_r;
        blk_nxt  = blk_r;
        data_nxt = data_r;
        lv_nxt   = lv_r;
        fs_nxt   = fs_r;
        if (!run) begin
            st_nxt   = ST_IDLE;
            div_nxt  = DIV_RST;
            data_nxt = '0;
            lv_nxt   = 1'b0;
            fs_nxt  = 1'b0;
        end else if (tick) begin
            lv_nxt = 1'b0;
            fs_nxt = 1'b0;
            case (st_r)
                ST_IDLE: begin
                    st_nxt = ST_FRAME;
                end
                ST_FRAME: begin
                    fs_nxt  = 1'b1;
                    blk_nxt = blank_len_i;
                    col_nxt = '0;
                    row_nxt = '0;
                    st_nxt  = ST_BLANK;
                end
                ST_BLANK: begin
                    if (blk_r == '0) begin
                        st_nxt = ST_LINES;
                    end else begin
                        blk_nxt = blk_r - 1'b1;
                    end
                end
                ST_LINES: begin
                    if (col_r < COL_W'(ACTIVE_COLS)
                        && row_r < ROW_W'(ACTIVE_ROWS)) begin
                        lv_nxt   = 1'b1;
                        data_nxt = pixel_i;
                    end
                    if (col_r == COL_W'(TOTAL_COLS - 1)) begin
                        col_nxt = '0;
                        if (row_r == ROW_W'(TOTAL_ROWS - 1)) begin
                            st_nxt = ST_FRAME;
                        end else begin
                            row_nxt = row_r + 1'b1;
                        end
                    end else begin
                        col_nxt = col_r + 1'b1;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r   <= ST_IDLE;
            div_r  <= DIV_RST;
            col_r  <= '0;
            row_r  <= '0;
            blk_r  <= BLANK_RST;
            data_r <= '0;
            lv_r   <= 1'b0;
            fs_r   <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            div_r  <= div_nxt;
            col_r  <= col_nxt;
            row_r  <= row_nxt;
            blk_r  <= blk_nxt;
            data_r <= data_nxt;
            lv_r   <= lv_nxt;
            fs_r   <= fs_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.pixel_data  = data_r;
    assign link.line_valid  = lv_r;
    assign link.frame_start = fs_r;

endmodule // pix_sensor

// ---- core/pix_port_pkg.sv ----
/*
 * shared constants for the sensor pixel output port and its capture end
 * assumes one 250 MHz clock standing in for the master clock domain
 */
package pix_port_pkg;

    localparam int unsigned DATA_W        = 8;
    localparam int unsigned TOTAL_COLS    = 414;
    localparam int unsigned TOTAL_ROWS    = 314;
    localparam int unsigned ACTIVE_COLS   = 400;
    localparam int unsigned ACTIVE_ROWS   = 300;
    localparam int unsigned COL_W         = 9;
    localparam int unsigned ROW_W         = 9;
    localparam int unsigned DIV_W         = 4;
    localparam int unsigned BLANK_W       = 16;
    localparam int unsigned ENABLE_MIN_CYC = 2;
    localparam int unsigned RESET_MIN_CYC = 8;
    localparam int unsigned CNT_W         = 4;
    localparam logic [DIV_W-1:0]   DIV_RST   = 4'h0;
    localparam logic [BLANK_W-1:0] BLANK_RST = 16'h0004;

endpackage

// ---- core/pix_port_if.sv ----
/*
 * interface joining the sensor end and the capture end
 * assumes both ends run on the same master clock
 */
`timescale 1ns/100ps
interface pix_port_if
    import pix_port_pkg::*;
    (input wire logic clk_i);

    logic              sensor_enable_in;
    logic              hw_reset_n;
    logic [DATA_W-1:0] pixel_data;
    logic              line_valid;
    logic              frame_start;

    modport sensor (
        input  clk_i,
        input  sensor_enable_in,
        input  hw_reset_n,
        output pixel_data,
        output line_valid,
        output frame_start
    );

    modport capture (
        input  clk_i,
        output sensor_enable_in,
        output hw_reset_n,
        input  pixel_data,
        input  line_valid,
        input  frame_start
    );

endinterface // pix_port_if

// ---- core/pix_capture.sv ----
/*
 * capture end: drives enable and reset, takes pixels while line-valid
 * assumes the sensor end shares the master clock
 */
`timescale 1ns/100ps
module pix_capture
    import pix_port_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    // user control
    input  wire logic              enable_req_i,
    input  wire logic              sensor_reset_req_i,
    // user data
    output logic [DATA_W-1:0]      pixel_o,
    output logic                   pixel_valid_o,
    output logic                   frame_start_o,
    // link
    pix_port_if.capture            link
);

    // ----------------------------------------
    // enable hold and reset stretch
    // ----------------------------------------
    logic [CNT_W-1:0] en_cnt_r, en_cnt_nxt;
    logic             en_r, en_nxt;
    logic [CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;

    always_comb begin
        en_nxt      = en_r;
        en_cnt_nxt  = en_cnt_r;
        rst_cnt_nxt = rst_cnt_r;
        if (en_cnt_r != CNT_W'(ENABLE_MIN_CYC - 1)) begin
            en_cnt_nxt = en_cnt_r + 1'b1;
        end else if (enable_req_i != en_r) begin
            en_nxt     = enable_req_i;
            en_cnt_nxt = '0;
        end
        if (sensor_reset_req_i) begin
            rst_cnt_nxt = CNT_W'(RESET_MIN_CYC);
        end else if (rst_cnt_r != '0) begin
            rst_cnt_nxt = rst_cnt_r - 1'b1;
        end
    end

    // ----------------------------------------
    // capture on rising edge (fast clock)
    // ----------------------------------------
    logic [DATA_W-1:0] pix_r, pix_nxt;
    logic              pv_r, pv_nxt;
    logic              fs_r, fs_nxt;

    always_comb begin
        pv_nxt  = link.line_valid;
        pix_nxt = link.line_valid ? link.pixel_data : pix_r;
        fs_nxt  = link.frame_start;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_r      <= 1'b0;
            en_cnt_r  <= '0;
            rst_cnt_r <= CNT_W'(RESET_MIN_CYC);
            pix_r     <= '0;
            pv_r      <= 1'b0;
            fs_r      <= 1'b0;
        end else begin
            en_r      <= en_nxt;
            en_cnt_r  <= en_cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            pix_r     <= pix_nxt;
            pv_r      <= pv_nxt;
            fs_r      <= fs_nxt;
        end
    end

    assign link.sensor_enable_in = en_r;
    assign link.hw_reset_n       = (rst_cnt_r == '0);
    assign pixel_o               = pix_r;
    assign pixel_valid_o         = pv_r;
    assign frame_start_o         = fs_r;

endmodule // pix_capture

// ---- verif/pix_port_props.sv ----
/* link checker: sync timing, reset and enable
   assumes one clock shared by both ends */
`timescale 1ns/100ps
module pix_port_props
    import pix_port_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              reset_n_i,
    input wire logic              sensor_enable_in,
    input wire logic              hw_reset_n,
    input wire logic [DATA_W-1:0] pixel_data,
    input wire logic              line_valid,
    input wire logic              frame_start
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic run = sensor_enable_in && hw_reset_n;
    property p_rst_idle;
        !hw_reset_n [*6] |-> !line_valid && !frame_start;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("sync active in reset");
    property p_en_idle;
        !sensor_enable_in [*6] |-> !line_valid && !frame_start;
    endproperty
    a_en_idle: assert property (p_en_idle)
        else $error("sync active while disabled");
    property p_fs_blank;
        $rose(frame_start) |-> !line_valid ##1 !line_valid;
    endproperty
    a_fs_blank: assert property (p_fs_blank)
        else $error("no blanking after frame start");
    property p_fs_pulse;
        $rose(frame_start) |-> ##[1:16] !frame_start;
    endproperty
    a_fs_pulse: assert property (p_fs_pulse)
        else $error("frame start not a pulse");
    property p_en_hold;
        $changed(sensor_enable_in) |=> $stable(sensor_enable_in);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enable held under two clocks");
    property p_rst_len;
        $fell(hw_reset_n) |=> !hw_reset_n [*7];
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset low under eight clocks");
    property p_lv_rise;
        $rose(line_valid) && run |=> line_valid;
    endproperty
    a_lv_rise: assert property (p_lv_rise)
        else $error("line valid high one clock only");
    property p_lv_fall;
        $fell(line_valid) && run |=> !line_valid;
    endproperty
    a_lv_fall: assert property (p_lv_fall)
        else $error("line valid low one clock only");
    c_row: cover property ($fell(line_valid));
    c_fs: cover property ($rose(frame_start));
    c_rst: cover property ($fell(hw_reset_n));
endmodule // pix_port_props

// ---- verif/tb_top.sv ----
/* bench: capture end facing sensor end
   assumes the core package and interface */
`timescale 1ns/100ps
module tb_top
    import pix_port_pkg::*;
;
    logic               clk_i = 1'b0;
    logic               reset_n_i = 1'b0;
    logic [DIV_W-1:0]   clk_div = 4'h0;
    logic [BLANK_W-1:0] blank_len = 16'h0004;
    logic [DATA_W-1:0]  pixel = 8'hA5;
    logic               en_req = 1'b0;
    logic               srst_req = 1'b0;
    logic [DATA_W-1:0]  pixel_o;
    logic               valid_o;
    logic               fs_o;
    int                 miscompares = 0;
    int                 samples_checked = 0;
    int                 n;
    always #2 clk_i = ~clk_i;
    pix_port_if pix_port_if_i (.clk_i(clk_i));
    pix_sensor pix_sensor_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .clk_div_i(clk_div), .blank_len_i(blank_len), .pixel_i(pixel),
        .link(pix_port_if_i));
    pix_capture pix_capture_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .enable_req_i(en_req), .sensor_reset_req_i(srst_req),
        .pixel_o(pixel_o), .pixel_valid_o(valid_o), .frame_start_o(fs_o),
        .link(pix_port_if_i));
    pix_port_props pix_port_props_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .sensor_enable_in(pix_port_if_i.sensor_enable_in),
        .hw_reset_n(pix_port_if_i.hw_reset_n),
        .pixel_data(pix_port_if_i.pixel_data),
        .line_valid(pix_port_if_i.line_valid),
        .frame_start(pix_port_if_i.frame_start));
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_valid();
        for (int t = 0; t < 4000 && valid_o !== 1'b1; t++) step(1);
    endtask
    task automatic run_len(output int len);
        len = 0;
        while (valid_o === 1'b1 && len < 2000) begin
            chk("pixel", {8'h00, pixel}, {8'h00, pixel_o});
            len++;
            step(1);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #80000;
        miscompares++;
        conclude();
    end
    initial begin
        step(2);
        reset_n_i = 1'b1;
        en_req = 1'b1;
        for (n = 0; n < 200 && fs_o !== 1'b1; n++) step(1);
        chk("frame start", 1, {15'h0, fs_o});
        wait_valid();
        run_len(n);
        chk("row length", 400, n[15:0]);
        for (n = 0; n < 100 && valid_o !== 1'b1; n++) step(1);
        chk("row gap", 14, n[15:0]);
        $display("test row done");
        srst_req = 1'b1;
        step(1);
        srst_req = 1'b0;
        for (n = 0; n < 20 && pix_port_if_i.hw_reset_n !== 1'b0; n++) step(1);
        for (n = 0; n < 50 && pix_port_if_i.hw_reset_n === 1'b0; n++) step(1);
        chk("reset span", 8, n[15:0]);
        chk("valid in reset", 0, {15'h0, pix_port_if_i.line_valid});
        $display("test reset done");
        wait_valid();
        en_req = 1'b0;
        step(8);
        chk("valid off", 0, {15'h0, pix_port_if_i.line_valid});
        chk("data off", 0, {8'h00, pix_port_if_i.pixel_data});
        $display("test disable done");
        clk_div = 4'h1;
        en_req = 1'b1;
        wait_valid();
        run_len(n);
        chk("slow row", 800, n[15:0]);
        $display("test divide done");
        conclude();
    end
endmodule // tb_top
